// ### src/deposition_process_sequencer.sv
// deposition_process_sequencer: two-channel layer state sequencer with
// APB register access, shutter contacts and power-level selection.
// assumes synchronous panel inputs and a single 40 MHz core clock.
`timescale 1ns/10ps

module deposition_process_sequencer
  import seq_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        indexer_done,
  input  wire logic [1:0]  final_thick,
  input  wire logic [15:0] measured_rate,
  output logic [1:0]       source_shutter,
  output logic [1:0]       sensor_shutter,
  output logic [1:0]       power_sel_0,
  output logic [1:0]       power_sel_1,
  output logic [15:0]      desired_rate_1,
  output logic [4:0]       state_code_0,
  output logic [4:0]       state_code_1
);

  if (CHANNELS != 2) begin : g_bad_channels
    $error("sequencer supports exactly two channels");
  end

  // ---------------------------------------------------------------------
  // apb slave; zero wait state, unmapped offsets answer with pslverr
  // ---------------------------------------------------------------------
  logic [31:0] cfg_reg, lay_a_reg, lay_b_reg, times_reg, rate_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pready_reg;
  logic [7:0]  layer_reg, layer_next;
  logic [1:0]  conflict_reg, conflict_next;   // [0] source, [1] sensor

  wire access    = psel && !penable;
  // writes and commands act at the edge that completes the access phase
  wire wr_access = psel && penable && pwrite && pready_reg;
  wire hit_cmd   = paddr == CMD_OFS;
  wire hit_cfg   = paddr == CFG_OFS;
  wire hit_la    = paddr == LAYER_A_OFS;
  wire hit_lb    = paddr == LAYER_B_OFS;
  wire hit_tm    = paddr == TIMES_OFS;
  wire hit_rate  = paddr == RATE_OFS;
  wire hit_pwr   = paddr == POWER_OFS;
  wire hit_st    = paddr == STATUS_OFS;
  wire hit_out   = paddr == OUT_OFS;
  wire mapped    = hit_cmd | hit_cfg | hit_la | hit_lb | hit_tm |
                   hit_rate | hit_pwr | hit_st | hit_out;

  wire cmd_start = wr_access && hit_cmd && pwdata[CMD_START_BIT];
  wire cmd_stop  = wr_access && hit_cmd && pwdata[CMD_STOP_BIT];
  wire cmd_reset = wr_access && hit_cmd && pwdata[CMD_RESET_BIT];
  wire crit_err  = wr_access && hit_cmd && pwdata[CMD_CRIT_BIT];

  layer_state_t st_reg [2];
  layer_state_t st_next [2];
  logic [7:0]   tmr_reg [2];
  logic [7:0]   tmr_next [2];
  logic [1:0]   sel_reg [2];
  logic [1:0]   sel_next [2];
  logic [1:0]   src_sh_reg, src_sh_next, sns_sh_reg, sns_sh_next;
  logic         stopped_reg, stopped_next;
  logic         paired_reg, paired_next;   // launched together by one start
  logic [15:0]  des1_reg, des1_next;

  wire [31:0] status_word = {conflict_reg, 4'h0, paired_reg, stopped_reg,
                             3'h0, st_reg[1], 3'h0, st_reg[0], layer_reg};

  assign prdata_next = !mapped ? 32'h0000_0000 :
                       hit_cfg  ? cfg_reg :
                       hit_la   ? lay_a_reg :
                       hit_lb   ? lay_b_reg :
                       hit_tm   ? times_reg :
                       hit_rate ? rate_reg :
                       hit_pwr  ? {28'h0, sel_reg[1], sel_reg[0]} :
                       hit_st   ? status_word :
                       hit_out  ? {12'h0, des1_reg, sns_sh_reg, src_sh_reg} :
                                  32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      if (access && !pwrite) prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_reg   <= CFG_RESET;
      lay_a_reg <= 32'h0000_0000;
      lay_b_reg <= 32'h0000_0001;
      times_reg <= 32'h0404_0404;
      rate_reg  <= 32'h0000_0064;
    end else if (wr_access) begin
      if (hit_cfg)  cfg_reg   <= pwdata;
      if (hit_la)   lay_a_reg <= pwdata;
      if (hit_lb)   lay_b_reg <= pwdata;
      if (hit_tm)   times_reg <= pwdata;
      if (hit_rate) rate_reg  <= pwdata;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------------
  wire [7:0]  first_layer = cfg_reg[CFG_FIRST_LSB +: 8];
  wire [7:0]  last_layer  = cfg_reg[CFG_LAST_LSB +: 8];
  wire        codep_cfg   = cfg_reg[CFG_CODEP_BIT];
  wire        ratio_en    = cfg_reg[CFG_RATIO_BIT];
  wire        shdly_en    = cfg_reg[CFG_SHDLY_BIT];
  wire        ctdly_en    = cfg_reg[CFG_CTDLY_BIT];
  wire        hold_in     = cfg_reg[CFG_HOLD_BIT];
  wire [7:0]  ratio_pct   = cfg_reg[CFG_RATIO_LSB +: 8];
  wire [7:0]  t_rise      = times_reg[TM_RISE_LSB +: 8];
  wire [7:0]  t_soak      = times_reg[TM_SOAK_LSB +: 8];
  wire [7:0]  t_ctdly     = times_reg[TM_CTDLY_LSB +: 8];
  wire [7:0]  t_index     = times_reg[TM_INDEX_LSB +: 8];
  wire [15:0] des0        = rate_reg[15:0];
  wire        same_src    = lay_a_reg[LAY_SRC_LSB +: 4] ==
                            lay_b_reg[LAY_SRC_LSB +: 4];
  wire        share_sns   = |(lay_a_reg[LAY_SNS_LSB +: 8] &
                              lay_b_reg[LAY_SNS_LSB +: 8]);

  // ratio: secondary desired rate = primary * pct / 100
  wire [23:0] ratio_prod  = des0 * ratio_pct;
  wire [15:0] ratio_rate  = 16'(ratio_prod / 24'd100);
  // rate error window: 5 percent of desired or the absolute floor
  wire [15:0] rate_err    = measured_rate > des0 ? measured_rate - des0 :
                                                   des0 - measured_rate;
  wire [15:0] tol_pct     = 16'((32'(des0) * RATE_TOL_PCT) / 100);
  wire        rate_ok     = rate_err <= tol_pct || rate_err <= RATE_TOL_ABS;

  wire busy0 = st_reg[0] != ST_READY && st_reg[0] != ST_IDLE &&
               st_reg[0] != ST_STOP;
  wire busy1 = st_reg[1] != ST_READY && st_reg[1] != ST_IDLE &&
               st_reg[1] != ST_STOP;
  wire both_enter = (st_reg[0] == ST_SHUT_DELAY || st_reg[0] == ST_SOAK2) &&
                    (st_reg[1] == ST_SHUT_DELAY || st_reg[1] == ST_SOAK2);
  wire sns_conf   = busy0 && busy1 && share_sns && !hold_in && both_enter;
  wire src_conf   = cmd_start && busy0 && same_src && !stopped_reg;

  // ---------------------------------------------------------------------
  // per-channel layer state machines
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      wire tdone = tmr_reg[gi] == 8'h00;
      wire prim_done = final_thick[0] && st_reg[0] == ST_DEPOSIT;
      always_comb begin
        st_next[gi]  = st_reg[gi];
        tmr_next[gi] = tmr_reg[gi] == 8'h00 ? 8'h00 : tmr_reg[gi] - 8'h01;
        sel_next[gi] = sel_reg[gi];
        case (st_reg[gi])
          ST_READY, ST_IDLE, ST_STOP: begin
            sel_next[gi] = 2'd0;
          end
          ST_SRC_SWITCH: begin
            if (lay_a_reg[LAY_IDLE_BIT]) sel_next[gi] = 2'd0;
            if (!indexer_done || tdone) begin
              st_next[gi]  = ST_RISE1;
              tmr_next[gi] = t_rise;
              sel_next[gi] = 2'd1;
            end
          end
          ST_RISE1: if (tdone) begin
            st_next[gi] = ST_SOAK1;
            tmr_next[gi] = t_soak;
          end
          ST_SOAK1: if (tdone) begin
            st_next[gi] = ST_RISE2;
            tmr_next[gi] = t_rise;
            sel_next[gi] = 2'd2;
          end
          ST_RISE2: if (tdone) begin
            st_next[gi] = ST_SOAK2;
            tmr_next[gi] = t_soak;
          end
          ST_SOAK2: if (tdone) begin
            if (gi == 1 && hold_in && !paired_reg)
              st_next[gi] = ST_HOLD;
            else if (shdly_en)
              st_next[gi] = ST_SHUT_DELAY;
            else if (ctdly_en) begin
              st_next[gi] = ST_CTRL_DELAY;
              tmr_next[gi] = t_ctdly;
            end else begin
              st_next[gi] = ST_DEPOSIT;
              sel_next[gi] = 2'd3;
            end
          end
          ST_HOLD: if (!hold_in) st_next[gi] = ST_SHUT_DELAY;
          ST_SHUT_DELAY: begin
            sel_next[gi] = 2'd3;
            if (rate_ok) st_next[gi] = ST_DEPOSIT;
          end
          ST_CTRL_DELAY: if (tdone) begin
            st_next[gi] = ST_DEPOSIT;
            sel_next[gi] = 2'd3;
          end
          ST_DEPOSIT: begin
            sel_next[gi] = 2'd3;
            if (final_thick[gi] && !(gi == 1 && paired_reg))
              st_next[gi] = ST_IDLE;
            else if (gi == 1 && paired_reg && prim_done)
              st_next[gi] = ST_IDLE;
          end
          default: st_next[gi] = ST_READY;
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // process control: start, stop, reset, errors, concurrency
  // ---------------------------------------------------------------------
  wire halt = cmd_stop || crit_err || src_conf || sns_conf;
  logic [1:0] resume_mask_reg, resume_mask_next;

  layer_state_t fin [2];
  logic [7:0]   ftmr [2];
  logic [1:0]   fsel [2];

  always_comb begin
    fin[0] = st_next[0];
    fin[1] = st_next[1];
    ftmr[0] = tmr_next[0];
    ftmr[1] = tmr_next[1];
    fsel[0] = sel_next[0];
    fsel[1] = sel_next[1];
    layer_next = layer_reg;
    stopped_next = stopped_reg;
    paired_next = paired_reg;
    conflict_next = conflict_reg;
    resume_mask_next = resume_mask_reg;
    if (stopped_reg) begin
      fin[0] = ST_STOP;
      fin[1] = ST_STOP;
      fsel[0] = 2'd0;
      fsel[1] = 2'd0;
      if (cmd_start) begin
        stopped_next = 1'b0;
        conflict_next = 2'b00;
        fin[0] = resume_mask_reg[0] ? ST_SRC_SWITCH : ST_IDLE;
        fin[1] = resume_mask_reg[1] ? ST_SRC_SWITCH : ST_IDLE;
        ftmr[0] = t_index;
        ftmr[1] = t_index;
      end else if (cmd_reset) begin
        stopped_next = 1'b0;
        conflict_next = 2'b00;
        paired_next = 1'b0;
        layer_next = first_layer;
        fin[0] = ST_READY;
        fin[1] = ST_READY;
      end
    end else if (halt && (busy0 || busy1 || cmd_stop)) begin
      stopped_next = 1'b1;
      resume_mask_next = {busy1, busy0};
      conflict_next = conflict_reg | {sns_conf, src_conf};
      fin[0] = ST_STOP;
      fin[1] = ST_STOP;
      fsel[0] = 2'd0;
      fsel[1] = 2'd0;
    end else if (cmd_start) begin
      if (!busy0 && layer_reg <= last_layer) begin
        fin[0] = ST_SRC_SWITCH;
        ftmr[0] = t_index;
        layer_next = layer_reg + 8'h01;
        paired_next = codep_cfg;
        if (codep_cfg) begin
          fin[1] = ST_SRC_SWITCH;
          ftmr[1] = t_index;
          layer_next = layer_reg + 8'h02;
        end
      end else if (busy0 && !busy1 && layer_reg <= last_layer) begin
        fin[1] = ST_SRC_SWITCH;
        ftmr[1] = t_index;
        paired_next = 1'b0;
        layer_next = layer_reg + 8'h01;
      end
    end
  end

  // ratio applies only to a pair launched by one start
  assign des1_next = (paired_reg && ratio_en) ? ratio_rate
                                              : rate_reg[31:16];

  // shutter contacts follow the state table
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      src_sh_next[i] = fin[i] == ST_CTRL_DELAY || fin[i] == ST_DEPOSIT;
      sns_sh_next[i] = fin[i] == ST_SOAK2 || fin[i] == ST_SHUT_DELAY ||
                       fin[i] == ST_CTRL_DELAY || fin[i] == ST_DEPOSIT ||
                       (fin[i] == ST_HOLD);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg[0]       <= ST_READY;
      st_reg[1]       <= ST_READY;
      tmr_reg[0]      <= 8'h00;
      tmr_reg[1]      <= 8'h00;
      sel_reg[0]      <= 2'd0;
      sel_reg[1]      <= 2'd0;
      src_sh_reg      <= 2'b00;
      sns_sh_reg      <= 2'b00;
      layer_reg       <= 8'h01;
      stopped_reg     <= 1'b0;
      paired_reg      <= 1'b0;
      conflict_reg    <= 2'b00;
      resume_mask_reg <= 2'b00;
      des1_reg        <= 16'h0000;
    end else begin
      st_reg[0]       <= fin[0];
      st_reg[1]       <= fin[1];
      tmr_reg[0]      <= ftmr[0];
      tmr_reg[1]      <= ftmr[1];
      sel_reg[0]      <= fsel[0];
      sel_reg[1]      <= fsel[1];
      src_sh_reg      <= src_sh_next;
      sns_sh_reg      <= sns_sh_next;
      layer_reg       <= layer_next;
      stopped_reg     <= stopped_next;
      paired_reg      <= paired_next;
      conflict_reg    <= conflict_next;
      resume_mask_reg <= resume_mask_next;
      if (!stopped_reg) des1_reg <= des1_next;
    end
  end

  assign source_shutter = src_sh_reg;
  assign sensor_shutter = sns_sh_reg;
  assign power_sel_0    = sel_reg[0];
  assign power_sel_1    = sel_reg[1];
  assign desired_rate_1 = des1_reg;
  assign state_code_0   = st_reg[0];
  assign state_code_1   = st_reg[1];

endmodule

// ### src/seq_pkg.sv
// seq_pkg: register map, field positions, reset values and timing counts
// for the deposition process sequencer.
// assumes a 40 MHz core clock and a 32-bit APB master.
package seq_pkg;

  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_OFS      = 8'h00;
  localparam logic [7:0] CFG_OFS      = 8'h04;
  localparam logic [7:0] LAYER_A_OFS  = 8'h08;
  localparam logic [7:0] LAYER_B_OFS  = 8'h0C;
  localparam logic [7:0] TIMES_OFS    = 8'h10;
  localparam logic [7:0] POWER_OFS    = 8'h14;
  localparam logic [7:0] RATE_OFS     = 8'h18;
  localparam logic [7:0] STATUS_OFS   = 8'h1C;
  localparam logic [7:0] OUT_OFS      = 8'h20;

  // ---------------------------------------------------------------------
  // command register bits (write one to issue)
  // ---------------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int CMD_CRIT_BIT  = 3;

  // ---------------------------------------------------------------------
  // config register fields
  // ---------------------------------------------------------------------
  localparam int CFG_FIRST_LSB   = 0;   // layer to start, 8 bits
  localparam int CFG_LAST_LSB    = 8;   // last layer, 8 bits
  localparam int CFG_CODEP_BIT   = 16;  // a start with channel 0 not busy co-deposits the next two layers
  localparam int CFG_RATIO_BIT   = 17;  // ratio control enable
  localparam int CFG_SHDLY_BIT   = 18;  // shutter delay enable
  localparam int CFG_CTDLY_BIT   = 19;  // control delay enable
  localparam int CFG_HOLD_BIT    = 20;  // soak hold for early layer
  localparam int CFG_RATIO_LSB   = 24;  // ratio percent, 8 bits

  // layer descriptor: source, sensor mask, idle power flag
  localparam int LAY_SRC_LSB     = 0;   // 4 bits
  localparam int LAY_SNS_LSB     = 8;   // 8-bit sensor mask
  localparam int LAY_IDLE_BIT    = 16;  // previous idle power nonzero

  // stage times in cycles, 8 bits each
  localparam int TM_RISE_LSB     = 0;
  localparam int TM_SOAK_LSB     = 8;
  localparam int TM_CTDLY_LSB    = 16;
  localparam int TM_INDEX_LSB    = 24;

  localparam logic [31:0] CFG_RESET = 32'h0000_0101;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int TIME_UNIT_US    = 1;
  localparam int UNIT_CYCLES     = (CLK_HZ / 1_000_000) * TIME_UNIT_US;

  // rate tolerance for shutter delay exit: 5 percent or 1 A/s (0.1 A/s lsb)
  localparam int RATE_TOL_PCT    = 5;
  localparam logic [15:0] RATE_TOL_ABS = 16'h000A;

  typedef enum logic [4:0] {
    ST_READY, ST_SRC_SWITCH, ST_RISE1, ST_SOAK1, ST_RISE2, ST_SOAK2,
    ST_HOLD, ST_SHUT_DELAY, ST_CTRL_DELAY, ST_DEPOSIT, ST_IDLE, ST_STOP
  } layer_state_t;

endpackage

// ### bench/deposition_sequencer_checker.sv
// deposition_sequencer_checker: port-level assertions on channel 0.
// assumes it is bound into the sequencer top with the package visible.
`timescale 1ns/10ps
module deposition_sequencer_checker
  import seq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [1:0]  source_shutter,
  input wire logic [1:0]  sensor_shutter,
  input wire logic [1:0]  power_sel_0,
  input wire logic [4:0]  state_code_0
);
  // ---------------------------------------------------------------
  // command decode and properties
  // ---------------------------------------------------------------
  wire logic cmd_wr;
  wire logic stopped;
  assign cmd_wr  = psel && penable && pready && pwrite && paddr == CMD_OFS;
  assign stopped = state_code_0 == ST_STOP;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no access-phase answer");
  a_stop_cmd: assert property (cmd_wr && pwdata[1] |=> stopped)
    else $error("stop command not taken");
  a_stop_outputs: assert property (stopped |->
    power_sel_0 == 2'h0 && !source_shutter[0] && !sensor_shutter[0])
    else $error("stopped with power or shutters on");
  a_stop_holds: assert property (stopped &&
    !(cmd_wr && pwdata[3:0] != 4'h0) |=> stopped)
    else $error("stop left without command");
  a_ready_closed: assert property (state_code_0 == ST_READY |->
    source_shutter[0] == 1'b0 && sensor_shutter[0] == 1'b0)
    else $error("shutter active in ready");
  a_pre_src_closed: assert property (
    state_code_0 inside {ST_SRC_SWITCH, ST_RISE1, ST_SOAK1, ST_RISE2,
    ST_SOAK2, ST_HOLD} |-> !source_shutter[0])
    else $error("source shutter open before deposit");
  a_soak2_sensor: assert property ($rose(state_code_0 == ST_SOAK2) |->
    sensor_shutter[0] && power_sel_0 == 2'h2)
    else $error("soak two without sensor shutter");
  a_ctrl_delay: assert property (state_code_0 == ST_CTRL_DELAY |->
    power_sel_0 == 2'h2 && source_shutter[0] && sensor_shutter[0])
    else $error("control delay outputs wrong");
  a_deposit_on: assert property (state_code_0 == ST_DEPOSIT |->
    source_shutter[0] && sensor_shutter[0] && power_sel_0 == 2'h3)
    else $error("deposit outputs wrong");
  a_crit_stop: assert property (cmd_wr && pwdata[3] && !(state_code_0
    inside {ST_READY, ST_IDLE, ST_STOP}) |=> stopped)
    else $error("critical error did not stop");
  a_resume_pre: assert property (stopped && cmd_wr &&
    pwdata[3:0] == 4'h1 |=> state_code_0 == ST_SRC_SWITCH)
    else $error("resume did not rerun from source switch");
  a_reset_ready: assert property (stopped && cmd_wr &&
    pwdata[3:0] == 4'h4 |=> state_code_0 == ST_READY)
    else $error("reset did not reach ready");
endmodule

bind deposition_process_sequencer deposition_sequencer_checker chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .source_shutter(source_shutter), .sensor_shutter(sensor_shutter),
  .power_sel_0(power_sel_0), .state_code_0(state_code_0)
);

// ### bench/vacuum_side_model.sv
// vacuum_side_model: crucible indexer and crystal thickness stand-in.
// assumes shutter contacts and power select from the sequencer.
`timescale 1ns/10ps
module vacuum_side_model #(
  parameter int THICK_CYC = 24,
  parameter int INDEX_CYC = 3
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  source_shutter,
  input  wire logic [1:0]  power_sel_0,
  output logic             indexer_done,
  output logic [1:0]       final_thick,
  output logic [15:0]      measured_rate
);
  int dep_cnt [2];
  int idle_cnt;
  always @(posedge core_clk) begin
    if (sys_rst || power_sel_0 != 2'h0) idle_cnt <= 0;
    else if (idle_cnt < INDEX_CYC) idle_cnt <= idle_cnt + 1;
    for (int i = 0; i < 2; i++) begin
      if (sys_rst || !source_shutter[i]) dep_cnt[i] <= 0;
      else if (dep_cnt[i] < THICK_CYC) dep_cnt[i] <= dep_cnt[i] + 1;
    end
  end
  // indexer_done stays high until power has rested at zero for INDEX_CYC cycles, then drops
  assign indexer_done = !(idle_cnt >= INDEX_CYC);
  // thickness builds only while the source shutter is open
  assign final_thick[0] = dep_cnt[0] >= THICK_CYC;
  assign final_thick[1] = dep_cnt[1] >= THICK_CYC;
  assign measured_rate = 16'h0064;
endmodule

// ### bench/deposition_process_sequencer_tb.sv
// deposition_process_sequencer_tb: APB command sequences with checks.
// assumes the vacuum side model closes the loop on the far side.
`timescale 1ns/10ps
module deposition_process_sequencer_tb
  import seq_pkg::*;
;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic indexer_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] final_thick, source_shutter, sensor_shutter;
  logic [1:0] power_sel_0, power_sel_1;
  logic [15:0] measured_rate, desired_rate_1;
  logic [4:0] state_code_0, state_code_1;
  logic e;
  int n_mismatch, samples_checked;

  deposition_process_sequencer uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .indexer_done(indexer_done),
    .final_thick(final_thick), .measured_rate(measured_rate),
    .source_shutter(source_shutter), .sensor_shutter(sensor_shutter),
    .power_sel_0(power_sel_0), .power_sel_1(power_sel_1),
    .desired_rate_1(desired_rate_1), .state_code_0(state_code_0),
    .state_code_1(state_code_1));
  vacuum_side_model far (.core_clk(core_clk), .sys_rst(sys_rst),
    .source_shutter(source_shutter), .power_sel_0(power_sel_0),
    .indexer_done(indexer_done), .final_thick(final_thick),
    .measured_rate(measured_rate));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, x, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk("pready", 0, 1);
      stop_test();
    end
    @(negedge core_clk);
  endtask
  task automatic wait_st(input logic [4:0] s);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge core_clk);
      if (state_code_0 === s) break;
    end
    if (n == 3000) begin
      chk("state wait", state_code_0, s);
      stop_test();
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(CFG_OFS, 1'b0, 32'h0);
    chk("cfg reset", q, CFG_RESET);
    chk("ready shutters", {source_shutter, sensor_shutter}, 0);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped data", q, 32'h0000_0000);
    chk("unmapped err", e, 1);
    apb(TIMES_OFS, 1'b1, 32'h0803_0404);
    apb(LAYER_A_OFS, 1'b1, 32'h0000_0101);
    apb(LAYER_B_OFS, 1'b1, 32'h0000_0202);
    apb(RATE_OFS, 1'b1, 32'h0000_0064);
    apb(CFG_OFS, 1'b1, 32'h0008_0201);
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_SOAK2);
    chk("soak2 shutters", {source_shutter[0], sensor_shutter[0]}, 1);
    wait_st(ST_CTRL_DELAY);
    chk("ctrl delay power", power_sel_0, 2'h2);
    wait_st(ST_DEPOSIT);
    apb(CMD_OFS, 1'b1, 32'h2);
    chk("stop state", state_code_0, ST_STOP);
    chk("stop outputs", {power_sel_0, source_shutter, sensor_shutter}, 0);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk("status", {q[12:8], q[7:0]}, {ST_STOP, 8'h02});
    apb(CMD_OFS, 1'b1, 32'h1);
    chk("resume pre", state_code_0 < ST_SHUT_DELAY, 1);
    wait_st(ST_IDLE);
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_DEPOSIT);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk("next layer", q[7:0], 8'h03);
    apb(CMD_OFS, 1'b1, 32'h8);
    chk("crit stop", state_code_0, ST_STOP);
    apb(CMD_OFS, 1'b1, 32'h4);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk("reset layer", {state_code_0, q[7:0]}, {ST_READY, 8'h01});
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_SOAK1);
    apb(CMD_OFS, 1'b1, 32'h1);
    chk("early start", state_code_1 !== ST_READY, 1);
    apb(CMD_OFS, 1'b1, 32'h2);
    apb(CMD_OFS, 1'b1, 32'h4);
    apb(LAYER_B_OFS, 1'b1, 32'h0000_0201);
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_SOAK1);
    apb(CMD_OFS, 1'b1, 32'h1);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk("src conflict", {state_code_0, q[31:30] != 2'h0}, {ST_STOP, 1'b1});
    apb(CMD_OFS, 1'b1, 32'h4);
    apb(LAYER_B_OFS, 1'b1, 32'h0000_0202);
    apb(CFG_OFS, 1'b1, 32'h320B_0201);
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_DEPOSIT);
    chk("pair launch", state_code_1 !== ST_READY, 1);
    chk("ratio rate", desired_rate_1, 16'h0032);
    apb(CMD_OFS, 1'b1, 32'h2);
    apb(CMD_OFS, 1'b1, 32'h4);
    apb(CFG_OFS, 1'b1, 32'h0014_0201);
    apb(CMD_OFS, 1'b1, 32'h1);
    wait_st(ST_SHUT_DELAY);
    chk("shut delay", {source_shutter[0], sensor_shutter[0]}, 1);
    wait_st(ST_DEPOSIT);
    chk("deposit power", power_sel_0, 2'h3);
    apb(CMD_OFS, 1'b1, 32'h1);
    repeat (40) @(negedge core_clk);
    chk("hold", {state_code_1, sensor_shutter[1]}, {ST_HOLD, 1'b1});
    apb(CFG_OFS, 1'b1, 32'h0004_0201);
    repeat (2) @(negedge core_clk);
    chk("hold exit", {state_code_1, power_sel_1}, {ST_DEPOSIT, 2'h3});
    stop_test();
  end
endmodule
